// ---- core/mbd_pkg.sv ----
// ============================================================
// shared constants and types
package mbd_pkg;

    // register map
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_INV = 5'h04;
    localparam logic [4:0] OFF_BITW = 5'h08;
    localparam logic [4:0] OFF_STAT = 5'h0C;
    localparam logic [4:0] OFF_MEAS = 5'h10;

    // control fields
    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_LSBF = 2;
    localparam int CTRL_EN = 3;
    localparam int CTRL_TERM = 4;
    localparam int CTRL_TAP_LSB = 5;
    localparam int CTRL_SRC0_LSB = 8;
    localparam int CTRL_SRC1_LSB = 10;
    localparam int CTRL_W = 12;

    // status fields
    localparam int STAT_BUSY_LSB = 0;
    localparam int STAT_OVR_LSB = 2;
    localparam int STAT_OWN_LSB = 4;

    // values after reset
    localparam logic [11:0] CTRL_RST = 12'h800;
    localparam logic [3:0] INV_RST = 4'h0;
    localparam logic [15:0] BITW_RST = 16'h0064;
    localparam logic [15:0] MEAS_RST = 16'hFFFF;

    // index of the last bit in a byte
    localparam logic [2:0] BYTE_LAST = 3'h7;

    typedef enum logic [1:0] {
        PHASE_CODE_RISING_ONE = 2'b00,
        PHASE_CODE_RISING_ZERO = 2'b01,
        DIFF_TRANSITION_IS_ONE = 2'b10,
        DIFF_TRANSITION_IS_ZERO = 2'b11
    } mbd_code_e;

    typedef enum logic [1:0] {
        TAP_HALF_DUPLEX = 2'b00,
        TAP_TWO_PAIR = 2'b01,
        TAP_SEGMENT = 2'b10
    } mbd_tap_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FIRST = 3'b001,
        ST_RUN = 3'b010,
        ST_FLUSH = 3'b011,
        ST_CLOSE = 3'b100
    } mbd_state_e;

    typedef struct packed {
        logic seg;
        logic ferr;
        logic [7:0] data;
    } mbd_byte_s;

endpackage

// ---- core/mbd_buf.sv ----
`timescale 1ns/1ps
// ============================================================
// two-entry byte buffer
module mbd_buf (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire mbd_pkg::mbd_byte_s in_data,
    output logic out_valid,
    input wire logic out_ready,
    output mbd_pkg::mbd_byte_s out_data
);
    mbd_pkg::mbd_byte_s mem_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rp_q];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) wp_q <= ~wp_q;
            if (pop) rp_q <= ~rp_q;
            if (push && !pop) cnt_q <= cnt_q + 2'h1;
            else if (pop && !push) cnt_q <= cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem_q[wp_q] <= in_data;
    end
endmodule // mbd_buf

// ---- core/mbd_decoder.sv ----
`timescale 1ns/1ps
// ============================================================
// two-unit manchester decoder with register port
// Summary of operation
// (R1) rising-one code: rise is 1, fall 0
// (R2) rising-zero code: rise is 0, fall 1
// (R3) every bit has a centre transition
// (R4) differential: value from bit-start transition
// (R5) transition-is-one: transition 1; is-zero opposite
// (R6) phase codes sampled at bit centre only
// (R7) sender sets first half-bit level correctly
// (R8) frame starts on idle-to-active change
// (R9) start edge only sets starting level
// (R10) next edge is first bit centre
// (R11) differential bits resolved one bit late
// (R12) bytes of eight; partial byte flagged
// (R13) constant configured bit width, measurable
// (R14) two units share code, rate, order
// (R15) per-channel polarity inversion
// (R16) three tap arrangements supported
// (R17) segment mode forwards and tags segment
// (R18) switchable bus termination
// (R19) frame closes after silent bit time
module mbd_decoder (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [4:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic [3:0] CH_LVL,
    input wire logic [3:0] CH_ACT,
    output logic TERM_EN,
    output logic [1:0] SEG_OUT,
    output logic [1:0] SEG_OE,
    output logic [1:0] BYTE_VALID,
    input wire logic [1:0] BYTE_READY,
    output mbd_pkg::mbd_byte_s [1:0] BYTE_DATA
);
    // ========================================================
    // register port
    logic [11:0] ctrl_q;
    logic [3:0] inv_q;
    logic [15:0] bitw_q;
    logic [31:0] rdata_q;
    logic [1:0] ovr_q;
    logic [1:0] own_q;
    logic [1:0] seg_out_q;
    logic [7:0] s1_q;
    logic [7:0] s2_q;

    wire wr_ctrl = WR && (ADDR == mbd_pkg::OFF_CTRL);
    wire wr_inv = WR && (ADDR == mbd_pkg::OFF_INV);
    wire wr_bitw = WR && (ADDR == mbd_pkg::OFF_BITW);
    wire wr_stat = WR && (ADDR == mbd_pkg::OFF_STAT);
    wire wr_meas = WR && (ADDR == mbd_pkg::OFF_MEAS);

    // shared settings for both units
    wire mbd_pkg::mbd_code_e code =
        mbd_pkg::mbd_code_e'(ctrl_q[mbd_pkg::CTRL_TYPE_LSB +: 2]); // [R14]
    wire lsb_first = ctrl_q[mbd_pkg::CTRL_LSBF];
    wire enable = ctrl_q[mbd_pkg::CTRL_EN];
    wire mbd_pkg::mbd_tap_e tap =
        mbd_pkg::mbd_tap_e'(ctrl_q[mbd_pkg::CTRL_TAP_LSB +: 2]);
    wire seg_mode = (tap == mbd_pkg::TAP_SEGMENT);
    wire is_diff = code[1];
    wire zero_sense = code[0];

    // tolerance windows derived from the bit width
    wire [16:0] half_w = {2'b00, bitw_q[15:1]};
    wire [16:0] quart_w = {3'b000, bitw_q[15:2]};
    wire [16:0] bnd_lim = half_w + quart_w;
    wire [16:0] tmo_lim = {1'b0, bitw_q} + quart_w;

    logic [1:0] unit_busy;
    logic [1:0] unit_act;
    logic [1:0] unit_raw;
    logic [1:0] ovr_set;
    logic [15:0] meas [2];

    wire [31:0] stat_word = {26'h0, own_q, ovr_q, unit_busy};
    wire [31:0] rd_mux =
        (ADDR == mbd_pkg::OFF_CTRL) ? {20'h0, ctrl_q} :
        (ADDR == mbd_pkg::OFF_INV) ? {28'h0, inv_q} :
        (ADDR == mbd_pkg::OFF_BITW) ? {16'h0, bitw_q} :
        (ADDR == mbd_pkg::OFF_STAT) ? stat_word :
        (ADDR == mbd_pkg::OFF_MEAS) ? {meas[1], meas[0]} : 32'h0;

    assign RDATA = rdata_q;
    assign TERM_EN = ctrl_q[mbd_pkg::CTRL_TERM]; // [R18]

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= mbd_pkg::CTRL_RST;
            inv_q <= mbd_pkg::INV_RST;
            bitw_q <= mbd_pkg::BITW_RST;
        end else begin
            if (wr_ctrl) ctrl_q <= WDATA[11:0];
            if (wr_inv) inv_q <= WDATA[3:0];
            if (wr_bitw) bitw_q <= WDATA[15:0]; // [R13]
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) rdata_q <= 32'h0;
        else rdata_q <= RD ? rd_mux : 32'h0;
    end

    // overrun is sticky; a new overrun beats a clear
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ovr_q <= 2'h0;
        end else begin
            ovr_q <= ovr_set |
                (ovr_q & ~(wr_stat ? WDATA[3:2] : 2'h0));
        end
    end

    // ========================================================
    // pin synchronisers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
        end else begin
            s1_q <= {CH_ACT, CH_LVL};
            s2_q <= s1_q;
        end
    end

    // ========================================================
    // segment router
    // the first segment to go active owns the link until idle;
    // our own drive then blocks the far unit from decoding echo
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            own_q <= 2'h0;
        end else if (!seg_mode) begin
            own_q <= 2'h0;
        end else if (own_q == 2'h0) begin
            if (unit_act[0]) own_q <= 2'h1; // [R17]
            else if (unit_act[1]) own_q <= 2'h2; // [R17]
        end else if ((own_q[0] && !unit_act[0]) ||
                     (own_q[1] && !unit_act[1])) begin
            own_q <= 2'h0;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) seg_out_q <= 2'h0;
        else seg_out_q <= {unit_raw[0], unit_raw[1]}; // [R17]
    end

    assign SEG_OUT = seg_out_q;
    assign SEG_OE = {own_q[0], own_q[1]};

    // ========================================================
    // decoding units
    for (genvar g = 0; g < 2; g++) begin : g_unit
        localparam int SRC_LSB = g ? mbd_pkg::CTRL_SRC1_LSB :
                                     mbd_pkg::CTRL_SRC0_LSB;
        mbd_pkg::mbd_state_e st_q;
        mbd_pkg::mbd_state_e st_d;
        logic [15:0] cnt_q;
        logic [15:0] ecnt_q;
        logic [15:0] meas_q;
        logic lvl_p_q;
        logic act_p_q;
        logic bnd_q;
        logic pend_q;
        logic pval_q;
        logic [7:0] sh_q;
        logic [2:0] nb_q;
        mbd_pkg::mbd_byte_s byte_w;
        logic push;
        logic in_ready;

        wire [1:0] src = ctrl_q[SRC_LSB +: 2];
        // polarity swap happens before any decoding
        wire lvl = s2_q[src] ^ inv_q[src]; // [R15]
        wire act = s2_q[4 + src];
        wire blocked = g ? own_q[0] : own_q[1];
        // half duplex taps one pair, other modes use both
        wire unit_on = enable && !blocked &&
            !(g == 1 && tap == mbd_pkg::TAP_HALF_DUPLEX); // [R16]
        wire edge_w = (lvl != lvl_p_q);
        wire start = unit_on && act && !act_p_q; // [R8]
        wire is_bnd = edge_w && ({1'b0, cnt_q} < bnd_lim);
        wire is_mid = edge_w && !is_bnd;
        wire tmo = ({1'b0, cnt_q} > tmo_lim); // [R19]
        wire in_first = (st_q == mbd_pkg::ST_FIRST);
        wire in_run = (st_q == mbd_pkg::ST_RUN);
        wire in_flush = (st_q == mbd_pkg::ST_FLUSH);
        wire in_close = (st_q == mbd_pkg::ST_CLOSE);
        wire first_mid = in_first && act && edge_w; // [R10]
        wire run_mid = in_run && act && !tmo && is_mid; // [R3]

        // phase codes: value is the new level at the centre edge
        wire ph_ev = !is_diff && (first_mid || run_mid); // [R6]
        wire ph_raw = lvl; // [R1]
        // differential: pending bit emitted at next centre edge, or in flush
        wire df_ev = is_diff && pend_q &&
            (run_mid || in_flush); // [R11]
        wire bit_ev = ph_ev || df_ev;
        wire bit_val = (is_diff ? pval_q : ph_raw) ^ zero_sense; // [R2] [R5]
        wire [7:0] sh_nxt = lsb_first ? {bit_val, sh_q[7:1]} :
                                        {sh_q[6:0], bit_val};
        wire full_push = bit_ev && (nb_q == mbd_pkg::BYTE_LAST); // [R12]
        wire part_push = in_close && (nb_q != 3'h0); // [R12]

        assign push = full_push || part_push;
        assign byte_w.seg = seg_mode && (g == 1); // [R17]
        assign byte_w.ferr = part_push; // [R12]
        assign byte_w.data = full_push ? sh_nxt : sh_q;
        assign ovr_set[g] = push && !in_ready;
        assign unit_busy[g] = (st_q != mbd_pkg::ST_IDLE);
        assign unit_act[g] = act && unit_on;
        assign unit_raw[g] = s2_q[src];
        assign meas[g] = meas_q;

        always_comb begin
            st_d = st_q;
            case (st_q)
                mbd_pkg::ST_IDLE: begin
                    if (start) st_d = mbd_pkg::ST_FIRST;
                end
                mbd_pkg::ST_FIRST: begin
                    if (!act || tmo) st_d = mbd_pkg::ST_CLOSE;
                    else if (edge_w) st_d = mbd_pkg::ST_RUN;
                end
                mbd_pkg::ST_RUN: begin
                    if (!act || tmo || !unit_on)
                        st_d = mbd_pkg::ST_FLUSH; // [R19]
                end
                mbd_pkg::ST_FLUSH: st_d = mbd_pkg::ST_CLOSE;
                mbd_pkg::ST_CLOSE: st_d = mbd_pkg::ST_IDLE;
                default: st_d = mbd_pkg::ST_IDLE;
            endcase
        end

        always_ff @(posedge MCLK or posedge RST) begin
            if (RST) begin
                st_q <= mbd_pkg::ST_IDLE;
                lvl_p_q <= 1'b0;
                act_p_q <= 1'b0;
            end else begin
                st_q <= st_d;
                lvl_p_q <= lvl; // [R9]
                act_p_q <= act;
            end
        end

        // time since the last centre edge or frame start, saturating
        always_ff @(posedge MCLK or posedge RST) begin
            if (RST) cnt_q <= 16'h0;
            else if (start || first_mid || run_mid) cnt_q <= 16'h0; // [R13]
            else if (cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h1;
        end

        // transition at bit start, seen between centre edges
        always_ff @(posedge MCLK or posedge RST) begin
            if (RST) bnd_q <= 1'b0;
            else if (first_mid || run_mid) bnd_q <= 1'b0;
            else if (in_run && is_bnd) bnd_q <= 1'b1; // [R4]
        end

        // start edge stands in for the first bit-start transition
        always_ff @(posedge MCLK or posedge RST) begin
            if (RST) begin
                pend_q <= 1'b0;
                pval_q <= 1'b0;
            end else if (in_close) begin
                pend_q <= 1'b0;
            end else if (first_mid) begin
                pend_q <= 1'b1; // [R11]
                pval_q <= 1'b1;
            end else if (run_mid) begin
                pend_q <= 1'b1;
                pval_q <= bnd_q; // [R4]
            end else if (df_ev) begin
                pend_q <= 1'b0;
            end
        end

        always_ff @(posedge MCLK or posedge RST) begin
            if (RST) begin
                sh_q <= 8'h00;
                nb_q <= 3'h0;
            end else if (in_close) begin
                sh_q <= 8'h00;
                nb_q <= 3'h0;
            end else if (bit_ev) begin
                sh_q <= sh_nxt;
                nb_q <= nb_q + 3'h1; // [R12]
            end
        end

        // shortest edge spacing seen, for rate measurement
        always_ff @(posedge MCLK or posedge RST) begin
            if (RST) begin
                ecnt_q <= 16'h0;
                meas_q <= mbd_pkg::MEAS_RST;
            end else begin
                if (edge_w || start) ecnt_q <= 16'h0;
                else if (ecnt_q != 16'hFFFF) ecnt_q <= ecnt_q + 16'h1;
                if (wr_meas) meas_q <= mbd_pkg::MEAS_RST;
                else if ((in_run && edge_w) && (ecnt_q < meas_q))
                    meas_q <= ecnt_q + 16'h1; // [R13]
            end
        end

        // a stall cannot halt the wire; two entries absorb it
        mbd_buf u_buf (
            .clk(MCLK),
            .rst(RST),
            .in_valid(push),
            .in_ready(in_ready),
            .in_data(byte_w),
            .out_valid(BYTE_VALID[g]),
            .out_ready(BYTE_READY[g]),
            .out_data(BYTE_DATA[g])
        );
    end

endmodule // mbd_decoder

// ---- sim/mbd_decoder_chk.sv ----
`timescale 1ns/1ps
// ============================================================
// port checker
module mbd_decoder_chk (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [4:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic TERM_EN,
    input wire logic [1:0] SEG_OE,
    input wire logic [1:0] BYTE_VALID,
    input wire logic [1:0] BYTE_READY,
    input wire mbd_pkg::mbd_byte_s [1:0] BYTE_DATA
);
    logic [11:0] ctrl_q;
    logic [15:0] bitw_q;
    wire logic seg_tap = ctrl_q[6:5] == 2'b10;
    // shadow of software writes; all twelve control bits are stored
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= mbd_pkg::CTRL_RST;
            bitw_q <= mbd_pkg::BITW_RST;
        end else if (WR && ADDR == mbd_pkg::OFF_CTRL) begin
            ctrl_q <= WDATA[11:0];
        end else if (WR && ADDR == mbd_pkg::OFF_BITW) begin
            bitw_q <= WDATA[15:0];
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    rdata_quiet_a: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside answer cycle");
    unmapped_rd_a: assert property (RD && ADDR > 5'h10 |=> RDATA == 32'h0)
        else $error("unmapped read not zero");
    ctrl_back_a: assert property (
        RD && ADDR == mbd_pkg::OFF_CTRL |=> RDATA == {20'h0, $past(ctrl_q)})
        else $error("control readback wrong");
    bitw_back_a: assert property (
        RD && ADDR == mbd_pkg::OFF_BITW |=> RDATA == {16'h0, $past(bitw_q)})
        else $error("bit width readback wrong");
    term_follow_a: assert property (TERM_EN == ctrl_q[4])
        else $error("termination not as configured");
    hold_zero_a: assert property (BYTE_VALID[0] && !BYTE_READY[0] |=>
        BYTE_VALID[0] && $stable(BYTE_DATA[0]))
        else $error("unit zero byte not held");
    hold_one_a: assert property (BYTE_VALID[1] && !BYTE_READY[1] |=>
        BYTE_VALID[1] && $stable(BYTE_DATA[1]))
        else $error("unit one byte not held");
    seg_excl_a: assert property (SEG_OE != 2'b11)
        else $error("both segments driven");
    seg_tap_a: assert property (!seg_tap [*3] |-> SEG_OE == 2'b00)
        else $error("segment driven outside segment mode");
    unit_tag_a: assert property (BYTE_VALID[0] |-> !BYTE_DATA[0].seg)
        else $error("unit zero byte tagged segment two");
endmodule // mbd_decoder_chk

bind mbd_decoder mbd_decoder_chk u_chk (.MCLK(MCLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TERM_EN(TERM_EN),
    .SEG_OE(SEG_OE), .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY),
    .BYTE_DATA(BYTE_DATA));

// ---- sim/mbd_tx.sv ----
`timescale 1ns/1ps
// ============================================================
// bus transmitter model for one channel
module mbd_tx #(
    parameter int HALF = 8
) (
    input wire logic clk,
    output logic lvl,
    output logic act
);
    logic drv = 1'b0;
    logic inv_q = 1'b0;
    logic busy = 1'b0;
    logic junk = 1'b0;
    // idle line has no defined level, so keep it moving
    always @(posedge clk) junk <= ~junk;
    assign lvl = busy ? drv ^ inv_q : junk;
    assign act = busy;

    // hold keeps the line active and static to force a timeout close
    task automatic send(input logic [1:0] code, input int n,
        input logic [23:0] b, input logic inv, input logic hold);
        logic l;
        logic v;
        l = 1'b0;
        for (int i = 0; i < n; i++) begin
            v = b[n-1-i];
            if (!code[1]) l = code[0] ? v : ~v;
            else if (i > 0 && v != code[0]) l = ~l;
            @(posedge clk);
            drv <= l;
            inv_q <= inv;
            busy <= 1'b1;
            repeat (HALF) @(posedge clk);
            drv <= ~l;
            l = ~l;
            repeat (HALF - 1) @(posedge clk);
        end
        if (hold) repeat (6 * HALF) @(posedge clk);
        @(posedge clk);
        busy <= 1'b0;
    endtask
endmodule // mbd_tx

// ---- sim/mbd_decoder_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    failures++; $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
// ============================================================
// decoder bench
module mbd_decoder_tb;
    localparam int BITW = 16;
    localparam logic [31:0] RV [6] = '{32'(mbd_pkg::CTRL_RST), 32'h0,
        32'(mbd_pkg::BITW_RST), 32'h0, {mbd_pkg::MEAS_RST, mbd_pkg::MEAS_RST},
        32'h0};
    logic MCLK, RST, WR, RD, TERM_EN;
    logic [4:0] ADDR;
    logic [31:0] WDATA, RDATA, d;
    wire logic [3:0] CH_LVL;
    wire logic [3:0] CH_ACT;
    logic [1:0] SEG_OUT, SEG_OE, BYTE_VALID, BYTE_READY, c;
    mbd_pkg::mbd_byte_s [1:0] BYTE_DATA;
    mbd_pkg::mbd_byte_s q;
    int failures = 0;
    int samples_checked = 0;
    int seed = 32'h19e1b1e1;
    logic [23:0] b;

    mbd_decoder DUT (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .CH_LVL(CH_LVL), .CH_ACT(CH_ACT),
        .TERM_EN(TERM_EN), .SEG_OUT(SEG_OUT), .SEG_OE(SEG_OE),
        .BYTE_VALID(BYTE_VALID), .BYTE_READY(BYTE_READY),
        .BYTE_DATA(BYTE_DATA));
    for (genvar g = 0; g < 4; g++) begin : ch
        mbd_tx #(.HALF(BITW / 2)) tx (.clk(MCLK), .lvl(CH_LVL[g]),
            .act(CH_ACT[g]));
    end

    function automatic logic [31:0] mk(input logic [1:0] code,
        input logic lsbf, input logic [1:0] tap, input logic [1:0] s1);
        return 32'({s1, 2'b00, 1'b0, tap, 2'b11, lsbf, code});
    endfunction
    // partial bytes are not realigned, so fewer bits sit at one end
    function automatic logic [9:0] pack(input logic [23:0] v, input int n,
        input logic lsbf, input logic seg);
        logic [7:0] a;
        a = 8'h00;
        for (int i = 0; i < n; i++) begin
            a = lsbf ? {v[n-1-i], a[7:1]} : {a[6:0], v[n-1-i]};
        end
        return {seg, n != 8, a};
    endfunction

    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        @(negedge MCLK);
        v = RDATA;
    endtask
    task automatic pop(input int k, output mbd_pkg::mbd_byte_s v);
        int n;
        n = 0;
        @(negedge MCLK);
        while (BYTE_VALID[k] !== 1'b1 && n < 1000) begin
            @(negedge MCLK);
            n++;
        end
        `CHK("byte arrival", 1'b1, BYTE_VALID[k])
        v = BYTE_DATA[k];
        @(posedge MCLK);
        BYTE_READY[k] <= 1'b1;
        @(posedge MCLK);
        BYTE_READY[k] <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("failures %0d checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    initial begin
        repeat (20000) @(posedge MCLK);
        failures++;
        tally_and_finish();
    end

    initial begin
        RST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 5'h00;
        WDATA = 32'h0;
        BYTE_READY = 2'b00;
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(5'(4 * i), d);
            `CHK("reset value", RV[i], d)
        end
        wr(mbd_pkg::OFF_BITW, BITW);
        for (int i = 0; i < 8; i++) begin
            c = 2'(i);
            wr(mbd_pkg::OFF_CTRL, mk(c, i[2], 2'b01, 2'b10));
            b = $random(seed);
            if (c[1]) b[7] = ~c[0];
            ch[0].tx.send(c, 8, b, 1'b0, 1'b0);
            pop(0, q);
            `CHK("byte", pack(b, 8, i[2], 0), q)
        end
        `CHK("termination", 1'b1, TERM_EN)
        for (int i = 0; i < 2; i++) begin
            c = i ? 2'b11 : 2'b00;
            wr(mbd_pkg::OFF_CTRL, mk(c, 1'b0, 2'b01, 2'b10));
            b = $random(seed);
            if (c[1]) b[4] = ~c[0];
            fork
                ch[0].tx.send(c, 5, b, 1'b0, 1'b1);
            join_none
            pop(0, q);
            `CHK("partial byte", pack(b, 5, 0, 0), q)
            `CHK("closed while active", 1'b1, CH_ACT[0])
            wait (CH_ACT[0] == 1'b0);
        end
        wr(mbd_pkg::OFF_INV, 32'h1);
        wr(mbd_pkg::OFF_CTRL, mk(2'b00, 1'b0, 2'b01, 2'b10));
        b = $random(seed);
        ch[0].tx.send(2'b00, 8, b, 1'b1, 1'b0);
        pop(0, q);
        `CHK("inverted", pack(b, 8, 0, 0), q)
        wr(mbd_pkg::OFF_INV, 32'h0);
        fork
            ch[0].tx.send(2'b00, 8, b, 1'b0, 1'b0);
            ch[2].tx.send(2'b00, 8, ~b, 1'b0, 1'b0);
        join
        pop(0, q);
        `CHK("unit zero", pack(b, 8, 0, 0), q)
        pop(1, q);
        `CHK("unit one", pack(~b, 8, 0, 0), q)
        b = $random(seed);
        ch[0].tx.send(2'b00, 24, b, 1'b0, 1'b0);
        for (int j = 0; j < 2; j++) begin
            pop(0, q);
            `CHK("burst", pack(b >> (16 - 8 * j), 8, 0, 0), q)
        end
        rd(mbd_pkg::OFF_STAT, d);
        `CHK("overrun", 32'h4, d)
        wr(mbd_pkg::OFF_STAT, 32'h4);
        rd(mbd_pkg::OFF_STAT, d);
        `CHK("overrun clear", 32'h0, d)
        `CHK("dropped byte", 1'b0, BYTE_VALID[0])
        wr(mbd_pkg::OFF_CTRL, mk(2'b00, 1'b0, 2'b10, 2'b01));
        for (int k = 0; k < 2; k++) begin
            b = $random(seed);
            fork
                if (k == 0) ch[0].tx.send(2'b00, 8, b, 1'b0, 1'b0);
                else ch[1].tx.send(2'b00, 8, b, 1'b0, 1'b0);
            join_none
            repeat (40) @(negedge MCLK);
            `CHK("segment drive", k ? 2'b01 : 2'b10, SEG_OE)
            pop(k, q);
            `CHK("segment tag", pack(b, 8, 0, k[0]), q)
            wait (CH_ACT[k] == 1'b0);
        end
        tally_and_finish();
    end
endmodule // mbd_decoder_tb
